/* rtl/ocrf_top.sv */
/*
 * Off-core response filter and two general-purpose counters for one core.
 * Assumes a classic Wishbone master on the core clock, a transaction completion
 * stream from the uncore interface and a timestamp-rate tick from the core.
 * Counting is combinational on the completion pulse, so the uncore must present
 * the qualifiers in the same cycle as its done pulse.
 */
`include "ocrf_map.svh"

// Operation
// - Event B7 with unit mask 01 qualifies transactions using filter zero.
// - Event B7 with unit mask 02 qualifies transactions using filter one.
// - This instance holds one core's private filter pair, shared with none.
// - Request-type select spans filter bits 15:0 and 49:44; set bit makes eligible.
// - Filter bits 30:16 qualify response type, including L2 hit.
// - For L2 misses, filter bits 37:31 qualify the snoop response.
// - Bit 38 pairs counters: zero counts occurrences, one counts outstanding cycles.
// - Bits 0,1,2 select demand loads, ownership reads, instruction fetches.
// - Bit 3 selects modified write-backs; bit 12 clean L2 write-backs.
// - Bit 48 selects dirty L1 evicts missing L2; bit 49 dirty L2 evicts.
// - Bits 4,5,6 select L2 hardware prefetch loads, ownership, fetches.
// - Bits 7,8,9 select L3-only hardware prefetch loads, ownership, fetches.
// - Bit 10 selects L1 and software prefetches except exclusive-ownership ones.
// - Bit 11 all streaming stores; 46 partial; 47 full 64-byte.
// - Bits 14:13 reserved, never set; bit 15 counts miscellaneous regardless of response.
// - Bit 44 selects uncached loads; bit 45 uncached stores.
// - Reference-cycle event on a general counter advances at timestamp rate while the core is not halted.
module ocrf_top
    import ocrf_pkg::*;
#(
    parameter int CNT_W = 48
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [11:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Completed transaction from the uncore interface
    input  wire logic        i_txn_done,
    input  wire logic [15:0] i_txn_req_lo,
    input  wire ocrf_req_t   i_txn_req_hi,
    input  wire ocrf_rsp_t   i_txn_rsp,
    input  wire logic        i_txn_l2_miss,
    input  wire ocrf_snp_t   i_txn_snp,
    input  wire logic        i_txn_other,
    // Outstanding request tracking for latency mode
    input  wire logic        i_req_issue,
    input  wire logic [15:0] i_req_lo,
    input  wire ocrf_req_t   i_req_hi,
    input  wire logic [5:0]  i_outstanding,
    // Timestamp-rate tick and core halt state
    input  wire logic        i_tsc_tick,
    input  wire logic        i_core_halted,
    // Counter overflow pulses
    output logic      [1:0]  o_overflow
);

    // Registers are 64 bits wide; each word index holds two 32-bit halves at bit 0 of adr
    logic [63:0]      offcore_filter_zero;
    logic [63:0]      offcore_filter_one;
    logic [16:0]      evsel [2];
    logic [CNT_W-1:0] count [2];
    ocrf_ack_e        ack_state;

    logic [10:0] widx;
    logic        whi;
    logic [63:0] wmask;
    logic [63:0] wdata;
    assign widx  = i_wb_adr[11:1];
    assign whi   = i_wb_adr[0];
    assign wdata = whi ? {i_wb_dat, 32'h0000_0000} : {32'h0000_0000, i_wb_dat};
    always_comb begin
        wmask = 64'h0000_0000_0000_0000;
        for (int b = 0; b < 4; b++) begin
            if (i_wb_sel[b]) begin
                wmask[(whi ? 32 : 0) + b*8 +: 8] = 8'hFF;
            end
        end
    end

    logic wr_go;
    assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && (ack_state == OCRF_ACK_IDLE);

    // Register index decode; the half bit steers the byte lanes and blocks high-half event select and counter writes
    logic hit_filter0;
    logic hit_filter1;
    logic hit_count0;
    logic hit_count1;
    assign hit_filter0 = ({1'b0, widx} == `OCRF_IDX_FILTER0);
    assign hit_filter1 = ({1'b0, widx} == `OCRF_IDX_FILTER1);
    assign hit_count0  = ({1'b0, widx} == `OCRF_IDX_COUNT0);
    assign hit_count1  = ({1'b0, widx} == `OCRF_IDX_COUNT1);

    // Byte-lane merge of a write into either filter; reserved request bits never stick
    logic [63:0] next_filter_zero;
    logic [63:0] next_filter_one;
    assign next_filter_zero = ((offcore_filter_zero & ~wmask) | (wdata & wmask))
                              & ~`OCRF_RSVD_MASK;
    assign next_filter_one  = ((offcore_filter_one & ~wmask) | (wdata & wmask))
                              & ~`OCRF_RSVD_MASK;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_state <= OCRF_ACK_IDLE;
        end else begin
            unique case (ack_state)
                OCRF_ACK_IDLE: begin
                    if (i_wb_cyc && i_wb_stb) begin
                        ack_state <= OCRF_ACK_DONE;
                    end
                end
                OCRF_ACK_DONE: begin
                    ack_state <= OCRF_ACK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && (ack_state == OCRF_ACK_IDLE);
        end
    end

    // Private filter pair for this core; nothing outside this instance can reach it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            offcore_filter_zero <= `OCRF_FILTER_RESET;
            offcore_filter_one  <= `OCRF_FILTER_RESET;
        end else if (wr_go) begin
            if (hit_filter0) begin
                offcore_filter_zero <= next_filter_zero;
            end
            if (hit_filter1) begin
                offcore_filter_one <= next_filter_one;
            end
        end
    end

    // Event selects: [7:0] event code, [15:8] unit mask, [16] enable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evsel[0] <= 17'h0_0000;
            evsel[1] <= 17'h0_0000;
        end else if (wr_go && !whi) begin
            if (i_wb_adr[11:1] == `OCRF_IDX_EVSEL0) begin
                evsel[0] <= 17'((32'(evsel[0]) & ~wmask[31:0]) | (i_wb_dat & wmask[31:0]));
            end
            if (i_wb_adr[11:1] == `OCRF_IDX_EVSEL1) begin
                evsel[1] <= 17'((32'(evsel[1]) & ~wmask[31:0]) | (i_wb_dat & wmask[31:0]));
            end
        end
    end

    // Counter roles while latency mode pairs them
    localparam int OCC_CNT = 0;
    localparam int WGT_CNT = 1;

    // Per-filter decode; both filters share one layout
    logic [63:0] filt [2];
    logic [21:0] req_sel [2];
    logic [14:0] rsp_sel [2];
    logic [6:0]  snp_sel [2];
    logic [1:0]  txn_hit;
    logic [1:0]  issue_hit;

    assign filt[0] = offcore_filter_zero;
    assign filt[1] = offcore_filter_one;

    generate
        for (genvar k = 0; k < 2; k++) begin : g_filt
            // Demand traffic
            logic       demand_load_select;
            logic       demand_ownership_select;
            logic       demand_fetch_select;
            // Write-backs and evictions
            logic       modified_writeback_select;
            logic       clean_writeback_select;
            logic       l1_dirty_evict_select;
            logic       l2_dirty_evict_select;
            // Hardware and software prefetches
            logic       l2_prefetch_load_select;
            logic       l2_prefetch_ownership_select;
            logic       l2_prefetch_fetch_select;
            logic       l3_prefetch_load_select;
            logic       l3_prefetch_ownership_select;
            logic       l3_prefetch_fetch_select;
            logic       l1_and_software_prefetch_select;
            // Streaming stores, uncached and miscellaneous traffic
            logic       stream_store_select;
            logic       partial_stream_select;
            logic       full_stream_select;
            logic       uncached_load_select;
            logic       uncached_store_select;
            logic       misc_request_select;
            logic [1:0] rsvd_select;
            // Outcome qualification
            logic       req_ok;
            logic       issue_ok;
            logic       out_ok;

            assign demand_load_select              = filt[k][`OCRF_BIT_DMD_LOAD];
            assign demand_ownership_select         = filt[k][`OCRF_BIT_DMD_OWN];
            assign demand_fetch_select             = filt[k][`OCRF_BIT_DMD_FETCH];
            assign modified_writeback_select       = filt[k][`OCRF_BIT_MOD_WB];
            assign clean_writeback_select          = filt[k][`OCRF_BIT_CLEAN_WB];
            assign l1_dirty_evict_select           = filt[k][`OCRF_BIT_L1_EVICT];
            assign l2_dirty_evict_select           = filt[k][`OCRF_BIT_L2_EVICT];
            assign l2_prefetch_load_select         = filt[k][`OCRF_BIT_L2PF_LOAD];
            assign l2_prefetch_ownership_select    = filt[k][`OCRF_BIT_L2PF_OWN];
            assign l2_prefetch_fetch_select        = filt[k][`OCRF_BIT_L2PF_FETCH];
            assign l3_prefetch_load_select         = filt[k][`OCRF_BIT_L3PF_LOAD];
            assign l3_prefetch_ownership_select    = filt[k][`OCRF_BIT_L3PF_OWN];
            assign l3_prefetch_fetch_select        = filt[k][`OCRF_BIT_L3PF_FETCH];
            assign l1_and_software_prefetch_select = filt[k][`OCRF_BIT_L1_SWPF];
            assign stream_store_select             = filt[k][`OCRF_BIT_STREAM];
            assign partial_stream_select           = filt[k][`OCRF_BIT_PART_STREAM];
            assign full_stream_select              = filt[k][`OCRF_BIT_FULL_STREAM];
            assign uncached_load_select            = filt[k][`OCRF_BIT_UNC_LOAD];
            assign uncached_store_select           = filt[k][`OCRF_BIT_UNC_STORE];
            assign misc_request_select             = filt[k][`OCRF_BIT_MISC];
            // Always clear, since writes never set them
            assign rsvd_select = filt[k][`OCRF_BIT_RSVD_MSB:`OCRF_BIT_RSVD_LSB];

            // Gathered in the order the uncore presents a class: {bits 49:44, bits 15:0}
            assign req_sel[k] = {l2_dirty_evict_select, l1_dirty_evict_select,
                                 full_stream_select, partial_stream_select,
                                 uncached_store_select, uncached_load_select,
                                 misc_request_select, rsvd_select,
                                 clean_writeback_select, stream_store_select,
                                 l1_and_software_prefetch_select,
                                 l3_prefetch_fetch_select, l3_prefetch_ownership_select,
                                 l3_prefetch_load_select,
                                 l2_prefetch_fetch_select, l2_prefetch_ownership_select,
                                 l2_prefetch_load_select,
                                 modified_writeback_select, demand_fetch_select,
                                 demand_ownership_select, demand_load_select};
            assign rsp_sel[k] = filt[k][`OCRF_RSP_MSB:`OCRF_RSP_LSB];
            assign snp_sel[k] = filt[k][`OCRF_SNP_MSB:`OCRF_SNP_LSB];

            assign req_ok   = |(req_sel[k] & {i_txn_req_hi, i_txn_req_lo});
            assign issue_ok = |(req_sel[k] & {i_req_hi, i_req_lo});

            always_comb begin
                if (i_txn_other) begin
                    // Miscellaneous requests count with any response type
                    out_ok = 1'b1;
                end else if (i_txn_l2_miss) begin
                    // Snoop outcome only means something once the L2 has missed
                    out_ok = |(snp_sel[k] & i_txn_snp);
                end else begin
                    out_ok = |(rsp_sel[k] & i_txn_rsp);
                end
            end

            assign txn_hit[k]   = i_txn_done && req_ok && out_ok;
            assign issue_hit[k] = i_req_issue && issue_ok;
        end
    endgenerate

    logic lat_mode;
    assign lat_mode = offcore_filter_zero[`OCRF_LAT_BIT];

    logic [CNT_W-1:0] inc [2];
    logic [1:0]       wrap;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_cnt
            logic             ev_en;
            logic [7:0]       ev_code;
            logic [7:0]       ev_mask;
            logic             is_oc;
            logic             is_ref;
            logic             uses_f0;
            logic             uses_f1;
            logic             sel_hit;
            logic             hit_count;
            logic [CNT_W-1:0] next_count;

            assign ev_en   = evsel[c][`OCRF_EVSEL_EN_BIT];
            assign ev_code = evsel[c][`OCRF_EVSEL_CODE_MSB:`OCRF_EVSEL_CODE_LSB];
            assign ev_mask = evsel[c][`OCRF_EVSEL_MASK_MSB:`OCRF_EVSEL_MASK_LSB];
            assign is_oc   = ev_en && (ev_code == `OCRF_EVT_OFFCORE);
            assign is_ref  = ev_en && (ev_code == `OCRF_EVT_REFCYC)
                             && (ev_mask == `OCRF_UNIT_MASK_REFCYC);
            assign uses_f0 = (ev_mask == `OCRF_UNIT_MASK_FILTER0);
            assign uses_f1 = (ev_mask == `OCRF_UNIT_MASK_FILTER1);
            // Unit mask picks which of the pair qualifies this counter; others count nothing outside latency mode
            assign sel_hit   = (uses_f0 && txn_hit[0]) || (uses_f1 && txn_hit[1]);
            assign hit_count = (c == 0) ? hit_count0 : hit_count1;

            always_comb begin
                inc[c] = '0;
                // Latency mode follows filter zero only; bit 38 of the second filter is ignored
                if (is_oc && lat_mode && c == WGT_CNT) begin
                    // Weighted cycles: add the outstanding count each cycle
                    inc[c] = CNT_W'(i_outstanding);
                end else if (is_oc && lat_mode && c == OCC_CNT) begin
                    inc[c] = CNT_W'(issue_hit[0]);
                end else if (is_oc) begin
                    inc[c] = CNT_W'(sel_hit);
                end else if (is_ref) begin
                    // Ticks at timestamp rate, gated off while the core is halted
                    inc[c] = CNT_W'(i_tsc_tick && !i_core_halted);
                end
            end
            assign wrap[c] = (count[c] + inc[c]) < count[c];

            // A software load wins over a count in the same cycle; that count is lost
            always_comb begin
                next_count = count[c] + inc[c];
                if (wr_go && !whi && hit_count) begin
                    next_count = CNT_W'(i_wb_dat);
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    count[c] <= '0;
                end else begin
                    count[c] <= next_count;
                end
            end
        end
    endgenerate

    // Overflow is a one-cycle pulse; software polls the counter for the rest
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_overflow <= 2'b00;
        end else begin
            o_overflow <= wrap;
        end
    end

    logic [63:0] rd64;
    always_comb begin
        rd64 = 64'h0000_0000_0000_0000;
        unique case (i_wb_adr[11:1])
            `OCRF_IDX_FILTER0: rd64 = offcore_filter_zero;
            `OCRF_IDX_FILTER1: rd64 = offcore_filter_one;
            `OCRF_IDX_EVSEL0:  rd64 = 64'(evsel[0]);
            `OCRF_IDX_EVSEL1:  rd64 = 64'(evsel[1]);
            `OCRF_IDX_COUNT0:  rd64 = 64'(count[0]);
            `OCRF_IDX_COUNT1:  rd64 = 64'(count[1]);
            default:           rd64 = 64'h0000_0000_0000_0000;
        endcase
    end

    // Half select of the addressed register
    logic [31:0] rd_word;
    assign rd_word = whi ? rd64[63:32] : rd64[31:0];

    // Read data is captured with the accepting edge and holds until the next access
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (i_wb_cyc && i_wb_stb && ack_state == OCRF_ACK_IDLE) begin
            o_wb_dat <= rd_word;
        end
    end

endmodule

/* common/ocrf_map.svh */
/*
 * Register offsets, field positions and event codes of the off-core response filter.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef OCRF_MAP_SVH
`define OCRF_MAP_SVH

`define OCRF_IDX_FILTER0       12'h1A6
`define OCRF_IDX_FILTER1       12'h1A7
`define OCRF_IDX_EVSEL0        12'h1A8
`define OCRF_IDX_EVSEL1        12'h1A9
`define OCRF_IDX_COUNT0        12'h1AA
`define OCRF_IDX_COUNT1        12'h1AB
`define OCRF_IDX_REFCTL        12'h1AC

`define OCRF_EVT_OFFCORE       8'hB7
`define OCRF_UNIT_MASK_FILTER0     8'h01
`define OCRF_UNIT_MASK_FILTER1     8'h02
`define OCRF_EVT_REFCYC        8'h3C
`define OCRF_UNIT_MASK_REFCYC      8'h01

`define OCRF_REQ_LO_MSB        15
`define OCRF_REQ_HI_LSB        44
`define OCRF_REQ_HI_MSB        49
`define OCRF_RSP_LSB           16
`define OCRF_RSP_MSB           30
`define OCRF_SNP_LSB           31
`define OCRF_SNP_MSB           37
`define OCRF_LAT_BIT           38
`define OCRF_RSVD_MASK         64'h0000_0000_0000_6000
`define OCRF_FILTER_RESET      64'h0000_0000_0000_0000
`define OCRF_EVSEL_EN_BIT      16
`define OCRF_EVSEL_CODE_LSB    0
`define OCRF_EVSEL_CODE_MSB    7
`define OCRF_EVSEL_MASK_LSB    8
`define OCRF_EVSEL_MASK_MSB    15

`define OCRF_BIT_DMD_LOAD      0
`define OCRF_BIT_DMD_OWN       1
`define OCRF_BIT_DMD_FETCH     2
`define OCRF_BIT_MOD_WB        3
`define OCRF_BIT_L2PF_LOAD     4
`define OCRF_BIT_L2PF_OWN      5
`define OCRF_BIT_L2PF_FETCH    6
`define OCRF_BIT_L3PF_LOAD     7
`define OCRF_BIT_L3PF_OWN      8
`define OCRF_BIT_L3PF_FETCH    9
`define OCRF_BIT_L1_SWPF       10
`define OCRF_BIT_STREAM        11
`define OCRF_BIT_CLEAN_WB      12
`define OCRF_BIT_RSVD_LSB      13
`define OCRF_BIT_RSVD_MSB      14
`define OCRF_BIT_MISC          15
`define OCRF_BIT_UNC_LOAD      44
`define OCRF_BIT_UNC_STORE     45
`define OCRF_BIT_PART_STREAM   46
`define OCRF_BIT_FULL_STREAM   47
`define OCRF_BIT_L1_EVICT      48
`define OCRF_BIT_L2_EVICT      49

`endif

/* common/ocrf_pkg.sv */
/*
 * Types shared by the off-core response filter.
 * Assumes a single clock domain.
 */
package ocrf_pkg;
    // Request class carried with each completed transaction, one per filter bit position
    typedef logic [5:0]  ocrf_req_t;
    typedef logic [14:0] ocrf_rsp_t;
    typedef logic [6:0]  ocrf_snp_t;
    typedef enum logic [1:0] {
        OCRF_ACK_IDLE,
        OCRF_ACK_DONE
    } ocrf_ack_e;
endpackage

/* verif/ocrf_assertions.sv */
/*
 * Bus and overflow timing checks for the off-core response filter.
 * Assumes binding to ocrf_top, one clock, async active-low reset.
 */
module ocrf_assertions (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic [1:0]  o_overflow
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_ack_once;
        $rose(i_wb_stb) && i_wb_cyc |=> o_wb_ack ##1 !o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack timing wrong");
    property p_ack_cause;
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_idle;
        !i_wb_cyc |=> !o_wb_ack;
    endproperty
    a_idle: assert property (p_idle) else $error("ack while idle");
    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_dat_hold;
        $changed(o_wb_dat) |-> o_wb_ack;
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_rst_quiet;
        $rose(i_rst_n) |-> !o_wb_ack && o_overflow == 2'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_ovf0;
        o_overflow[0] |=> !o_overflow[0];
    endproperty
    a_ovf0: assert property (p_ovf0) else $error("overflow zero held");
    property p_ovf1;
        o_overflow[1] |=> !o_overflow[1];
    endproperty
    a_ovf1: assert property (p_ovf1) else $error("overflow one held");
endmodule

bind ocrf_top ocrf_assertions u_chk (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_wb_cyc   (i_wb_cyc),
    .i_wb_stb   (i_wb_stb),
    .o_wb_dat   (o_wb_dat),
    .o_wb_ack   (o_wb_ack),
    .o_overflow (o_overflow)
);

/* verif/ocrf_uncore_model.sv */
/*
 * Uncore completion stream model: one pulse per completed transaction.
 * Assumes the caller starts each completion after a clock edge.
 */
module ocrf_uncore_model
    import ocrf_pkg::*;
(
    // Clock
    input  wire logic  i_clk,
    // Completion stream
    output logic       o_done,
    output logic [15:0] o_lo,
    output ocrf_req_t  o_hi,
    output ocrf_rsp_t  o_rsp,
    output logic       o_miss,
    output ocrf_snp_t  o_snp,
    output logic       o_other
);
    initial begin
        {o_done, o_lo, o_hi, o_rsp, o_miss, o_snp, o_other} = '0;
    end

    task automatic send(input logic [15:0] lo, input ocrf_req_t hi, input ocrf_rsp_t rsp,
                        input logic miss, input ocrf_snp_t snp, input logic oth);
        @(posedge i_clk);
        o_done <= 1'b1;
        {o_lo, o_hi, o_rsp, o_miss, o_snp, o_other} <= {lo, hi, rsp, miss, snp, oth};
        @(posedge i_clk);
        o_done <= 1'b0;
        // Qualifiers mean nothing between completions, so show garbage
        {o_lo, o_hi, o_rsp, o_miss, o_snp, o_other} <= ~{lo, hi, rsp, miss, snp, oth};
    endtask
endmodule

/* verif/tb_top.sv */
/*
 * Register and counting tests for the off-core response filter.
 * Assumes word addresses {index, half} and the uncore model beside the design.
 */
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] F0 = 12'h34C, F1 = 12'h34E, E0 = 12'h350, E1 = 12'h352;
    localparam logic [11:0] C0 = 12'h354, C1 = 12'h356, UNM = 12'h358;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, done, miss, oth;
    logic tick = 0, halted = 0;
    logic [11:0] adr = '0;
    logic [31:0] dat = '0, rdat, rd, e0 = '0, e1 = '0;
    logic [15:0] lo;
    logic [5:0]  hi;
    logic [14:0] rsp;
    logic [6:0]  snp;
    logic [1:0]  ovf;
    logic [63:0] f, r;
    int error_cnt = 0, checks_done = 0, b;

    always #2 clk = ~clk;

    // Narrow counters so that a wrap is reachable in a short run
    ocrf_top #(.CNT_W(32)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_txn_done(done), .i_txn_req_lo(lo), .i_txn_req_hi(hi),
        .i_txn_rsp(rsp), .i_txn_l2_miss(miss), .i_txn_snp(snp), .i_txn_other(oth),
        .i_req_issue(1'b0), .i_req_lo(16'h0), .i_req_hi(6'h0), .i_outstanding(6'h0),
        .i_tsc_tick(tick), .i_core_halted(halted), .o_overflow(ovf));
    ocrf_uncore_model model (.i_clk(clk), .o_done(done), .o_lo(lo), .o_hi(hi),
        .o_rsp(rsp), .o_miss(miss), .o_snp(snp), .o_other(oth));

    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        if (ack !== 1'b1) error_cnt++;
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #40000;
        error_cnt++;
        complete_run;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(F0, 32'h0);
        rdchk(F1 + 12'h1, 32'h0);
        rdchk(C0, 32'h0);
        wb(1'b1, UNM, 32'hFFFFFFFF);
        rdchk(UNM, 32'h0);
        $display("test reset and unmapped done");
        wb(1'b1, F0, 32'hFFFFFFFF);
        rdchk(F0, 32'hFFFF9FFF);
        wb(1'b1, F0 + 12'h1, 32'h0003F07F);
        rdchk(F0 + 12'h1, 32'h0003F07F);
        $display("test filter fields done");
        wb(1'b1, E0, 32'h000101B7);
        for (int i = 0; i < 22; i++) begin
            b = (i < 16) ? i : i + 28;
            if (b == 13 || b == 14) continue;
            r = 64'h1 << b;
            f = r | 64'h1_0000;
            wb(1'b1, F0, f[31:0]);
            wb(1'b1, F0 + 12'h1, f[63:32]);
            model.send(r[15:0], r[49:44], 15'h1, 1'b0, 7'h0, 1'b0);
            e0++;
            model.send(r[15:0], r[49:44], 15'h2, 1'b0, 7'h0, 1'b0);
            rdchk(C0, e0);
        end
        $display("test request classes done");
        wb(1'b1, F0, 32'h0);
        wb(1'b1, F0 + 12'h1, 32'h0);
        wb(1'b1, F1, 32'h00010001);
        wb(1'b1, E1, 32'h000102B7);
        model.send(16'h1, 6'h0, 15'h1, 1'b0, 7'h0, 1'b0);
        e1++;
        rdchk(C1, e1);
        rdchk(C0, e0);
        wb(1'b1, F0, 32'h80000001);
        model.send(16'h1, 6'h0, 15'h0, 1'b1, 7'h1, 1'b0);
        e0++;
        model.send(16'h1, 6'h0, 15'h7FFF, 1'b0, 7'h0, 1'b0);
        e1++;
        model.send(16'h1, 6'h0, 15'h1, 1'b1, 7'h2, 1'b0);
        rdchk(C0, e0);
        wb(1'b1, F0, 32'h00008000);
        model.send(16'h8000, 6'h0, 15'h0, 1'b0, 7'h0, 1'b1);
        e0++;
        rdchk(C0, e0);
        $display("test qualifiers done");
        wb(1'b1, E1, 32'h0001013C);
        ticks(5);
        e1 += 5;
        halted <= 1'b1;
        ticks(3);
        halted <= 1'b0;
        rdchk(C1, e1);
        wb(1'b1, C1, 32'hFFFFFFFF);
        ticks(1);
        @(posedge clk);
        `CHK(ovf, 2'b10)
        rdchk(C1, 32'h0);
        $display("test reference cycles done");
        complete_run;
    end
endmodule
